/* verilog/i2sf_pkg.sv */
// constants and state carriers for the i2c status flag block
package i2sf_pkg;

  ////////////////////////////////////////////////////////////////
  // register addresses on the plain register port
  localparam logic [1:0] ADR_STATUS = 2'h0;
  localparam logic [1:0] ADR_CTRL = 2'h1;
  localparam logic [1:0] ADR_OWN = 2'h2;
  localparam logic [1:0] ADR_RX = 2'h3;

  ////////////////////////////////////////////////////////////////
  // status flag positions
  localparam int B_RX = 5;
  localparam int B_NACK = 4;
  localparam int B_STOP = 3;
  localparam int B_AL = 2;
  localparam int B_AAS = 1;
  localparam logic [7:0] FLAG_MASK = 8'h3e;

  // control bit positions
  localparam int C_MST = 0;
  localparam int C_TX = 1;
  localparam int C_ACK_DECISION_ENABLE = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [6:0] RST_OWN = 7'h00;

  // bus constants
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // event toggle indices, link to cpu
  localparam int E_RX = 0;
  localparam int E_NACK = 1;
  localparam int E_STOP = 2;
  localparam int E_AL = 3;
  localparam int E_AAS = 4;
  localparam int NEV = 5;

  ////////////////////////////////////////////////////////////////
  // cpu clock domain state
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] armed;
    logic [2:0] ctrl;
    logic [6:0] own;
    logic [7:0] rx;
    logic [7:0] rdat;
    logic [NEV-1:0] t1;
    logic [NEV-1:0] t2;
    logic [NEV-1:0] t3;
    logic s1;
    logic s2;
  } i2sf_cpu_t;

  // link clock domain state
  typedef struct packed {
    logic [9:0] c1;
    logic [9:0] c2;
    logic [1:0] p1;
    logic [1:0] p2;
    logic [1:0] p3;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic seen;
    logic susp;
    logic [NEV-1:0] tgl;
    logic [7:0] hold;
  } i2sf_link_t;

  // link reset value, pin stages idle high so no false edge follows reset
  localparam i2sf_link_t RST_LINK = '{p1: 2'h3, p2: 2'h3, p3: 2'h3, default: '0};

endpackage : i2sf_pkg

/* verilog/i2sf_status_flags.sv */
// i2c bus status flags with link-side event detection
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////
module i2sf_status_flags (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_int,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic xfer_suspend
);

  i2sf_pkg::i2sf_cpu_t s_q;
  i2sf_pkg::i2sf_cpu_t s_d;
  i2sf_pkg::i2sf_link_t l_q;
  i2sf_pkg::i2sf_link_t l_d;

  ////////////////////////////////////////////////////////////////
  // link side decoded view
  logic scl;
  logic sda;
  logic scl_o;
  logic sda_o;
  logic start;
  logic stop;
  logic rise;
  logic mst;
  logic tx;
  logic ack_decision_enable;
  logic [6:0] own_l;
  logic [7:0] byte_l;
  logic addr_hit;

  // second sync stage and its delayed copy only
  assign scl = l_q.p2[1];
  assign sda = l_q.p2[0];
  assign scl_o = l_q.p3[1];
  assign sda_o = l_q.p3[0];
  assign start = scl & scl_o & sda_o & ~sda;
  assign stop = scl & scl_o & ~sda_o & sda;
  assign rise = scl & ~scl_o;

  // configuration seen in the link domain
  assign mst = l_q.c2[7 + i2sf_pkg::C_MST];
  assign tx = l_q.c2[7 + i2sf_pkg::C_TX];
  assign ack_decision_enable = l_q.c2[7 + i2sf_pkg::C_ACK_DECISION_ENABLE];
  assign own_l = l_q.c2[6:0];
  assign byte_l = {l_q.sh[6:0], sda};
  assign addr_hit = (byte_l[7:1] == own_l) | (byte_l[7:1] == i2sf_pkg::GC_ADDR);

  ////////////////////////////////////////////////////////////////
  // link domain next state
  always_comb begin
    l_d = l_q;
    // config is quasi static, two stage level sync
    l_d.c1 = {s_q.ctrl, s_q.own};
    l_d.c2 = l_q.c1;
    // pin synchronisers
    l_d.p1 = {scl_in, sda_in};
    l_d.p2 = l_q.p1;
    l_d.p3 = l_q.p2;
    if (start) begin
      l_d.cnt = 4'h0;
      l_d.first = 1'b1;
      l_d.susp = 1'b0;
      if (mst & sda_int) begin
        l_d.tgl[i2sf_pkg::E_AL] = ~l_q.tgl[i2sf_pkg::E_AL];
      end
    end else if (stop) begin
      l_d.cnt = 4'h0;
      l_d.first = 1'b0;
      l_d.susp = 1'b0;
      l_d.seen = 1'b0;
      if (l_q.seen) begin
        l_d.tgl[i2sf_pkg::E_STOP] = ~l_q.tgl[i2sf_pkg::E_STOP];
      end
    end else if (rise) begin
      if (l_q.cnt != i2sf_pkg::ACK_SLOT) begin
        l_d.sh = byte_l;
        l_d.cnt = l_q.cnt + 4'h1;
        if (mst & tx & (sda_int != sda)) begin
          l_d.tgl[i2sf_pkg::E_AL] = ~l_q.tgl[i2sf_pkg::E_AL];
        end
        if (l_q.cnt == i2sf_pkg::LAST_BIT) begin
          l_d.seen = 1'b1;
          if (l_q.first & ~mst & addr_hit) begin
            l_d.tgl[i2sf_pkg::E_AAS] = ~l_q.tgl[i2sf_pkg::E_AAS];
          end else if (~tx) begin
            // hold stays put for eight scl edges
            l_d.hold = byte_l;
            l_d.tgl[i2sf_pkg::E_RX] = ~l_q.tgl[i2sf_pkg::E_RX];
          end
        end
      end else begin
        // acknowledge slot
        l_d.cnt = 4'h0;
        l_d.first = 1'b0;
        if (tx & sda & ack_decision_enable) begin
          l_d.tgl[i2sf_pkg::E_NACK] = ~l_q.tgl[i2sf_pkg::E_NACK];
          l_d.susp = 1'b1;
        end
      end
    end
  end

  // link domain registers
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      l_q <= i2sf_pkg::RST_LINK;
    end else begin
      l_q <= l_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // cpu domain view
  logic [i2sf_pkg::NEV-1:0] ev;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic st_wr;
  logic st_rd;
  logic rx_rd;

  assign ev = s_q.t2 ^ s_q.t3;
  assign st_wr = wr_en & (addr == i2sf_pkg::ADR_STATUS);
  assign st_rd = rd_en & (addr == i2sf_pkg::ADR_STATUS);
  assign rx_rd = rd_en & (addr == i2sf_pkg::ADR_RX);

  // events mapped onto flag positions
  always_comb begin
    set_v = 8'h00;
    set_v[i2sf_pkg::B_RX] = ev[i2sf_pkg::E_RX];
    set_v[i2sf_pkg::B_NACK] = ev[i2sf_pkg::E_NACK];
    set_v[i2sf_pkg::B_STOP] = ev[i2sf_pkg::E_STOP];
    set_v[i2sf_pkg::B_AL] = ev[i2sf_pkg::E_AL];
    set_v[i2sf_pkg::B_AAS] = ev[i2sf_pkg::E_AAS];
  end

  ////////////////////////////////////////////////////////////////
  // cpu domain next state
  always_comb begin
    s_d = s_q;
    clr_v = 8'h00;
    // toggle event sync, third stage for edge
    s_d.t1 = l_q.tgl;
    s_d.t2 = s_q.t1;
    s_d.t3 = s_q.t2;
    s_d.s1 = l_q.susp;
    s_d.s2 = s_q.s1;
    // a read of one arms that bit for clearing
    if (st_rd) begin
      s_d.armed = s_q.armed | s_q.flags;
    end
    if (wr_en) begin
      unique case (addr)
        i2sf_pkg::ADR_STATUS: begin
          clr_v = s_q.armed & ~wdata & i2sf_pkg::FLAG_MASK;
          s_d.armed = s_q.armed & ~clr_v;
        end
        i2sf_pkg::ADR_CTRL: s_d.ctrl = wdata[2:0];
        i2sf_pkg::ADR_OWN: s_d.own = wdata[7:1];
        i2sf_pkg::ADR_RX: s_d.ctrl = s_q.ctrl; // read only
      endcase
    end
    if (rx_rd) begin
      clr_v[i2sf_pkg::B_RX] = 1'b1;
    end
    if (ev[i2sf_pkg::E_RX]) begin
      s_d.rx = l_q.hold;
    end
    // set wins over any clear
    s_d.flags = ((s_q.flags & ~clr_v) | set_v) & i2sf_pkg::FLAG_MASK;
    // a flag that went low needs a fresh read of one before a clear
    s_d.armed = s_d.armed & s_d.flags;
    // read data for the next cycle only
    s_d.rdat = i2sf_pkg::RST_BYTE;
    if (rd_en) begin
      unique case (addr)
        i2sf_pkg::ADR_STATUS: s_d.rdat = s_q.flags;
        i2sf_pkg::ADR_CTRL: s_d.rdat = {5'h00, s_q.ctrl};
        i2sf_pkg::ADR_OWN: s_d.rdat = {s_q.own, 1'b0};
        i2sf_pkg::ADR_RX: s_d.rdat = s_q.rx;
      endcase
    end
  end

  // cpu domain registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q.flags <= i2sf_pkg::RST_BYTE;
      s_q.armed <= i2sf_pkg::RST_BYTE;
      s_q.ctrl <= i2sf_pkg::RST_CTRL;
      s_q.own <= i2sf_pkg::RST_OWN;
      s_q.rx <= i2sf_pkg::RST_BYTE;
      s_q.rdat <= i2sf_pkg::RST_BYTE;
      s_q.t1 <= '0;
      s_q.t2 <= '0;
      s_q.t3 <= '0;
      s_q.s1 <= 1'b0;
      s_q.s2 <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rd_data = s_q.rdat;
  assign xfer_suspend = s_q.s2;

  ////////////////////////////////////////////////////////////////
  // checks, cpu domain
  a_rx_set: assert property (@(posedge clock) disable iff (!reset_n)
    ev[i2sf_pkg::E_RX] |=> s_q.flags[i2sf_pkg::B_RX])
    else $error("rx full not set after byte");

  a_clr_unarmed: assert property (@(posedge clock) disable iff (!reset_n)
    st_wr & ~s_q.armed[i2sf_pkg::B_STOP] & s_q.flags[i2sf_pkg::B_STOP] |=> s_q.flags[i2sf_pkg::B_STOP])
    else $error("flag cleared without prior read");

  a_clr_armed: assert property (@(posedge clock) disable iff (!reset_n)
    st_wr & s_q.armed[i2sf_pkg::B_STOP] & ~wdata[i2sf_pkg::B_STOP] & ~ev[i2sf_pkg::E_STOP]
    |=> ~s_q.flags[i2sf_pkg::B_STOP])
    else $error("armed flag not cleared by zero write");

  a_rx_rd_clr: assert property (@(posedge clock) disable iff (!reset_n)
    rx_rd & ~ev[i2sf_pkg::E_RX] |=> ~s_q.flags[i2sf_pkg::B_RX])
    else $error("rx data read did not clear rx full");

  a_set_wins: assert property (@(posedge clock) disable iff (!reset_n)
    (|set_v) |=> ((s_q.flags & $past(set_v)) == $past(set_v)))
    else $error("clear beat a same cycle set");

  a_rd_status: assert property (@(posedge clock) disable iff (!reset_n)
    st_rd |=> rd_data == $past(s_q.flags))
    else $error("status read data wrong");

  ////////////////////////////////////////////////////////////////
  // checks, link domain
  a_al_mismatch: assert property (@(posedge link_clk) disable iff (!reset_n)
    ~start & ~stop & rise & (l_q.cnt != i2sf_pkg::ACK_SLOT) & mst & tx & (sda_int != sda)
    |=> $changed(l_q.tgl[i2sf_pkg::E_AL]))
    else $error("sda mismatch did not flag arbitration lost");

  a_al_start: assert property (@(posedge link_clk) disable iff (!reset_n)
    start & mst & sda_int |=> $changed(l_q.tgl[i2sf_pkg::E_AL]))
    else $error("start while sda high did not flag arbitration lost");

  a_nack_susp: assert property (@(posedge link_clk) disable iff (!reset_n)
    ~start & ~stop & rise & (l_q.cnt == i2sf_pkg::ACK_SLOT) & tx & sda & ack_decision_enable
    |=> $changed(l_q.tgl[i2sf_pkg::E_NACK]) & l_q.susp)
    else $error("no ack not flagged or not suspended");

  a_ack_ignored: assert property (@(posedge link_clk) disable iff (!reset_n)
    ~start & ~stop & rise & (l_q.cnt == i2sf_pkg::ACK_SLOT) & ~ack_decision_enable
    |=> $stable(l_q.tgl[i2sf_pkg::E_NACK]) & (l_q.susp == $past(l_q.susp)))
    else $error("ack value not ignored with decision off");

  a_stop_flag: assert property (@(posedge link_clk) disable iff (!reset_n)
    stop & l_q.seen |=> $changed(l_q.tgl[i2sf_pkg::E_STOP]) ##1 1'b1)
    else $error("stop after frame not flagged");

  a_addr_match: assert property (@(posedge link_clk) disable iff (!reset_n)
    ~start & ~stop & rise & (l_q.cnt == i2sf_pkg::LAST_BIT) & l_q.first & ~mst & addr_hit
    |=> $changed(l_q.tgl[i2sf_pkg::E_AAS]))
    else $error("address match not flagged");

endmodule : i2sf_status_flags

`default_nettype wire

/* sim/i2sf_bus_model.sv */
// far-side i2c master model driving the bus lines for the status flag bench
`timescale 1ns/100ps
`default_nettype none
module i2sf_bus_model (
  input wire logic link_clk,
  output logic scl,
  output logic sda,
  output logic sda_int
);
  int hp = 6; // half bit in link clocks, raised for a slow partner

  // lines idle high on their pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    sda_int = 1'b1;
  end

  // wait one half bit
  task automatic half();
    repeat (hp) @(posedge link_clk);
  endtask : half

  // start: sda falls while scl high, own level chosen by caller
  task automatic start(input logic own_hi);
    sda_int <= own_hi;
    sda <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask : start

  // one bit, sda moved only while scl is low
  task automatic bit_out(input logic b, input logic own);
    @(posedge link_clk);
    sda <= b;
    sda_int <= own;
    half();
    scl <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : bit_out

  // eight bits msb first, then the ack slot with own sda released
  task automatic frame(input logic [7:0] d, input logic ackb, input int flip);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i], d[i] ^ (i == flip));
    end
    bit_out(ackb, 1'b1);
  endtask : frame

  // stop: sda rises while scl high
  task automatic stop();
    half();
    sda <= 1'b0;
    sda_int <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    sda_int <= 1'b1;
    half();
  endtask : stop
endmodule : i2sf_bus_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the i2c status flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic xfer_suspend;
  logic scl;
  logic sda;
  logic sda_int;
  logic [7:0] exp_q[$];
  logic [7:0] e_m;
  logic pend = 1'b0;
  logic [7:0] exp_f;
  logic [7:0] d;
  logic [7:0] n;
  logic [6:0] own;
  int mismatches = 0;
  int n_checks = 0;

  ////////////////////////////////////////////////////////////////
  i2sf_status_flags dut (.clock(clock), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_int(sda_int), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .xfer_suspend(xfer_suspend));
  i2sf_bus_model bus (.link_clk(link_clk), .scl(scl), .sda(sda), .sda_int(sda_int));

  // cpu clock and unrelated link clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  // read data checker, one cycle after each read strobe
  always @(posedge clock) begin
    if (pend) begin
      e_m = exp_q.pop_front();
      `CHK("rd_data", e_m, rd_data)
    end
    pend <= rd_en;
  end

  ////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd_en <= 1'b0;
  endtask : rd
  // let link events cross into the cpu domain
  task automatic settle();
    repeat (12) @(posedge clock);
  endtask : settle
  // check flags, clear them and read back
  task automatic clr();
    rd(i2sf_pkg::ADR_STATUS, exp_f);
    wr(i2sf_pkg::ADR_STATUS, 8'h00);
    rd(i2sf_pkg::ADR_STATUS, 8'h00);
  endtask : clr
  // one framed byte, stop left to the caller
  task automatic go(input logic own_hi, input logic [7:0] b, input logic ackb, input int flip);
    bus.start(own_hi);
    bus.frame(b, ackb, flip);
    settle();
  endtask : go
  task automatic fin();
    bus.stop();
    settle();
  endtask : fin
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // watchdog against a hung run
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(44));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    note("reset");
    own = {1'b1, 6'($urandom)};
    d = 8'($urandom);
    wr(i2sf_pkg::ADR_OWN, {own, 1'b0});
    rd(i2sf_pkg::ADR_OWN, {own, 1'b0});
    wr(i2sf_pkg::ADR_CTRL, 8'h00);
    bus.start(1'b0);
    bus.frame({own, 1'b0}, 1'b0, -1);
    bus.frame(d, 1'b0, -1);
    fin();
    wr(i2sf_pkg::ADR_STATUS, 8'h00);
    rd(i2sf_pkg::ADR_STATUS, 8'h2a);
    rd(i2sf_pkg::ADR_RX, d);
    rd(i2sf_pkg::ADR_STATUS, 8'h0a);
    wr(i2sf_pkg::ADR_STATUS, 8'h08);
    exp_f = 8'h08;
    clr();
    note("own address");
    bus.hp = 10;
    go(1'b0, 8'h01, 1'b0, -1);
    fin();
    exp_f = 8'h0a;
    clr();
    bus.hp = 6;
    note("general call");
    n = {1'b0, 6'($urandom) | 6'h01, 1'b1};
    go(1'b0, n, 1'b0, -1);
    fin();
    rd(i2sf_pkg::ADR_STATUS, 8'h28);
    rd(i2sf_pkg::ADR_RX, n);
    exp_f = 8'h08;
    clr();
    note("other address");
    wr(i2sf_pkg::ADR_CTRL, 8'h07);
    go(1'b0, d, 1'b1, -1);
    `CHK("xfer_suspend", 1'b1, xfer_suspend)
    fin();
    `CHK("xfer_suspend", 1'b0, xfer_suspend)
    exp_f = 8'h18;
    clr();
    note("nack enabled");
    wr(i2sf_pkg::ADR_CTRL, 8'h03);
    go(1'b0, d, 1'b1, -1);
    `CHK("xfer_suspend", 1'b0, xfer_suspend)
    fin();
    exp_f = 8'h08;
    clr();
    note("nack ignored");
    go(1'b0, d, 1'b0, 3);
    fin();
    exp_f = 8'h0c;
    clr();
    note("sda mismatch");
    go(1'b1, d, 1'b0, -1);
    fin();
    exp_f = 8'h0c;
    clr();
    note("start while high");
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
